// file: design/gbd_pkg.sv
// Constants and types shared by the bus command decoder.
// Notes on behaviour
// - Bytes taken with attention true are interface commands or addresses.
// - Bytes taken with attention false pass on as device data only while addressed to listen.
// - Only controller drives attention, clear and remote enable; device drives service request.
// - While remote enable is true the device may go remote.
// - Byte accompanied by end marker is flagged as last of message.
// - Interface clear returns the device to talker and listener idle.
// - Service request held asserted until the service need is cleared.
// - Universal commands act without any addressing.
// - Local lockout disables the local key and front panel inputs.
// - Device clear returns the device to power-up defaults.
// - Serial poll enable enters serial poll mode.
// - Serial poll disable leaves serial poll mode.
// - Addressed commands act only while addressed to listen, except group trigger with get_unaddressed_i set.
// - Selective clear acts as device clear but only when addressed.
// - Go-to-local leaves remote mode and also releases lockout.
// - Group trigger starts the configured action; optionally without addressing.
// - Own listen address is primary address ORed with hex 20.
// - Own talk address is primary address ORed with hex 40.
// - Secondary command group bytes are ignored; a listener with remote enable true still goes remote on one.
// - Unlisten drops listener addressing; untalk drops talker addressing.
// - All bus lines are active low.
// - Primary address is a five-bit value 0 to 31.
// - Command codes 01,04,08,11,14,18,19,3f,5f decode as listed.
// - Unlisten gives listener idle; untalk gives talker idle.
package gbd_pkg;
   localparam logic [6:0] GBD_CMD_GTL = 7'h01;
   localparam logic [6:0] GBD_CMD_SDC = 7'h04;
   localparam logic [6:0] GBD_CMD_GET = 7'h08;
   localparam logic [6:0] GBD_CMD_LLO = 7'h11;
   localparam logic [6:0] GBD_CMD_DCL = 7'h14;
   localparam logic [6:0] GBD_CMD_SPE = 7'h18;
   localparam logic [6:0] GBD_CMD_SPD = 7'h19;
   localparam logic [6:0] GBD_CMD_UNL = 7'h3f;
   localparam logic [6:0] GBD_CMD_UNT = 7'h5f;
   localparam logic [1:0] GBD_GRP_LAG = 2'h1;
   localparam logic [1:0] GBD_GRP_TAG = 2'h2;
   localparam logic [1:0] GBD_GRP_SCG = 2'h3;
   localparam logic [6:0] GBD_LAG_BASE = 7'h20;
   localparam logic [6:0] GBD_TAG_BASE = 7'h40;
   localparam logic [2:0] GBD_SYNC_RST = 3'h7;
   localparam logic [7:0] GBD_BYTE_RST = 8'h00;

   typedef enum logic [1:0] {
      GBD_HS_IDLE = 2'b00,
      GBD_HS_WAIT = 2'b01,
      GBD_HS_DONE = 2'b10
   } gbd_hs_t;
endpackage

// file: design/gbd_sync.sv
// Three-stage synchroniser for one active-low bus line.
`timescale 1ns/100ps
module gbd_sync
   import gbd_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic line_n_i,
   output logic level_o
);
   typedef struct packed {
      logic [2:0] sh;
      logic level;
   } gbd_sync_t;
   gbd_sync_t s_q, s_d;

   // Stage one is only read by stage two; the level moves when stages two and three agree.
   always_comb begin
      s_d = s_q;
      s_d.sh = {s_q.sh[1:0], line_n_i};
      if (s_q.sh[1] == s_q.sh[2]) begin
         s_d.level = ~s_q.sh[2];
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         s_q <= '{sh: GBD_SYNC_RST, level: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign level_o = s_q.level;
endmodule // gbd_sync

// file: design/gbd_decoder.sv
// Bus command decoder: uniline lines, multiline commands and data hand-off.
`timescale 1ns/100ps
module gbd_decoder
   import gbd_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic atn_n_i,
   input wire logic ifc_n_i,
   input wire logic ren_n_i,
   input wire logic eoi_n_i,
   input wire logic [7:0] dio_n_i,
   input wire logic byte_accepted_i,
   input wire logic [4:0] primary_addr_i,
   input wire logic get_unaddressed_i,
   input wire logic service_need_i,
   output logic srq_n_o,
   output logic srq_n_oe_o,
   output logic remote_o,
   output logic lockout_o,
   output logic panel_enable_o,
   output logic poll_mode_o,
   output logic listen_o,
   output logic talk_o,
   output logic dev_clear_o,
   output logic trigger_o,
   output logic data_valid_o,
   output logic [7:0] data_o,
   output logic data_last_o
);
   typedef struct packed {
      logic remote;
      logic lockout;
      logic poll;
      logic listen;
      logic talk;
      logic clr;
      logic trig;
      logic dval;
      logic [7:0] data;
      logic last;
      logic srq;
      logic panel;
   } gbd_state_t;

   logic atn, ifc, ren, eoi;
   logic [7:0] dio;
   gbd_state_t s_q, s_d;

   // Compares a command byte's low seven bits to a code; bit 7 is a don't care.
   function automatic logic is_cmd(input logic [7:0] b, input logic [6:0] code);
      is_cmd = (b[6:0] == code);
   endfunction

   // All bus lines come from another domain and pass the three-stage filter.
   gbd_sync u_atn (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .line_n_i(atn_n_i), .level_o(atn));
   gbd_sync u_ifc (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .line_n_i(ifc_n_i), .level_o(ifc));
   gbd_sync u_ren (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .line_n_i(ren_n_i), .level_o(ren));
   gbd_sync u_eoi (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .line_n_i(eoi_n_i), .level_o(eoi));

   // Data lines are inverted inside the filter, so dio holds true-level bits.
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_dio
         gbd_sync u_dio (
            .clk_sys_i(clk_sys_i),
            .rst_i(rst_i),
            .line_n_i(dio_n_i[gi]),
            .level_o(dio[gi])
         );
      end
   endgenerate

   // Next-state logic. Later assignments win, so interface clear has the last word.
   always_comb begin
      s_d = s_q;
      s_d.clr = 1'b0;
      s_d.trig = 1'b0;
      s_d.dval = 1'b0;
      s_d.srq = service_need_i;
      if (!ren) begin
         s_d.remote = 1'b0;
         s_d.lockout = 1'b0;
      end
      // The handshake block pulses byte_accepted_i once the byte is stable on the lines.
      if (byte_accepted_i) begin
         if (atn) begin
            if (s_q.listen && ren) begin
               s_d.remote = 1'b1;
            end
            if (is_cmd(dio, GBD_CMD_LLO)) begin
               s_d.lockout = 1'b1;
            end else if (is_cmd(dio, GBD_CMD_DCL)) begin
               s_d.clr = 1'b1;
               s_d.poll = 1'b0;
            end else if (is_cmd(dio, GBD_CMD_SPE)) begin
               s_d.poll = 1'b1;
            end else if (is_cmd(dio, GBD_CMD_SPD)) begin
               s_d.poll = 1'b0;
            end else if (is_cmd(dio, GBD_CMD_SDC)) begin
               s_d.clr = s_q.listen;
               if (s_q.listen) begin
                  s_d.poll = 1'b0;
               end
            end else if (is_cmd(dio, GBD_CMD_GTL)) begin
               if (s_q.listen) begin
                  s_d.remote = 1'b0;
                  s_d.lockout = 1'b0;
               end
            end else if (is_cmd(dio, GBD_CMD_GET)) begin
               s_d.trig = s_q.listen | get_unaddressed_i;
            end else if (is_cmd(dio, GBD_CMD_UNL)) begin
               s_d.listen = 1'b0;
            end else if (is_cmd(dio, GBD_CMD_UNT)) begin
               s_d.talk = 1'b0;
            end else if (dio[6:0] == (GBD_LAG_BASE | {2'b00, primary_addr_i})) begin
               s_d.listen = 1'b1;
               s_d.talk = 1'b0;
               if (ren) begin
                  s_d.remote = 1'b1;
               end
            end else if (dio[6:0] == (GBD_TAG_BASE | {2'b00, primary_addr_i})) begin
               s_d.talk = 1'b1;
               s_d.listen = 1'b0;
            end else if (dio[6:5] == GBD_GRP_TAG) begin
               s_d.talk = 1'b0; // Another talker was addressed.
            end
            // Secondary group bytes fall through every branch; only the listener remote update above applies to them.
         end else if (s_q.listen) begin
            s_d.dval = 1'b1;
            s_d.data = dio;
            s_d.last = eoi;
         end
      end
      if (ifc) begin
         s_d.listen = 1'b0;
         s_d.talk = 1'b0;
         s_d.poll = 1'b0;
      end
      // The panel enable is registered so the output needs no gate after the flop.
      s_d.panel = ~s_d.lockout;
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         s_q <= '{remote: 1'b0, lockout: 1'b0, poll: 1'b0, listen: 1'b0, talk: 1'b0,
                  clr: 1'b0, trig: 1'b0, dval: 1'b0, data: GBD_BYTE_RST, last: 1'b0,
                  srq: 1'b0, panel: 1'b1};
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs come straight from the state register, except srq_n_o which is tied low; the pin is open drain.
   assign srq_n_o = 1'b0;
   assign srq_n_oe_o = s_q.srq;
   assign remote_o = s_q.remote;
   assign lockout_o = s_q.lockout;
   assign panel_enable_o = s_q.panel;
   assign poll_mode_o = s_q.poll;
   assign listen_o = s_q.listen;
   assign talk_o = s_q.talk;
   assign dev_clear_o = s_q.clr;
   assign trigger_o = s_q.trig;
   assign data_valid_o = s_q.dval;
   assign data_o = s_q.data;
   assign data_last_o = s_q.last;
endmodule // gbd_decoder

// file: verification/gbd_decoder_assertions.sv
// Port checker for the bus command decoder.
`timescale 1ns/100ps
module gbd_checker
   import gbd_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic ifc_n_i,
   input wire logic [7:0] dio_n_i,
   input wire logic byte_accepted_i,
   input wire logic [4:0] primary_addr_i,
   input wire logic get_unaddressed_i,
   input wire logic service_need_i,
   input wire logic srq_n_oe_o,
   input wire logic srq_n_o,
   input wire logic panel_enable_o,
   input wire logic lockout_o,
   input wire logic poll_mode_o,
   input wire logic listen_o,
   input wire logic talk_o,
   input wire logic dev_clear_o,
   input wire logic trigger_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   // Clear and trigger trace back to an accept pulse; rises of listen, talk, poll and lockout trace to the byte on the lines.
   AST_CLR_SRC: assert property (dev_clear_o |-> $past(byte_accepted_i))
      else $error("clear without byte");
   AST_TRIG_SRC: assert property (trigger_o |-> $past(byte_accepted_i)
      && ($past(listen_o) || $past(get_unaddressed_i))) else $error("bad trigger");
   AST_MLA: assert property ($rose(listen_o)
      |-> (~$past(dio_n_i) & 8'h7f) == {3'h1, $past(primary_addr_i)}) else $error("bad listen");
   AST_MTA: assert property ($rose(talk_o)
      |-> (~$past(dio_n_i) & 8'h7f) == {3'h2, $past(primary_addr_i)}) else $error("bad talk");
   AST_SPE: assert property ($rose(poll_mode_o)
      |-> (~$past(dio_n_i) & 8'h7f) == {1'b0, GBD_CMD_SPE}) else $error("bad poll");
   AST_LLO: assert property ($rose(lockout_o)
      |-> (~$past(dio_n_i) & 8'h7f) == {1'b0, GBD_CMD_LLO}) else $error("bad lockout");
   AST_SRQ: assert property (service_need_i [*2] |-> srq_n_oe_o)
      else $error("srq not held");
   AST_SRQ_REL: assert property (!service_need_i [*2] |-> !srq_n_oe_o)
      else $error("srq not released");
   AST_SRQ_LVL: assert property (srq_n_oe_o |-> !srq_n_o)
      else $error("srq not driven low");
   AST_PANEL: assert property (panel_enable_o == !lockout_o)
      else $error("panel enable wrong");
   AST_IFC: assert property ($fell(ifc_n_i) |-> ##[1:6] !listen_o && !talk_o)
      else $error("ifc not idle");
   cover property ($rose(listen_o));
   cover property (trigger_o);
   cover property (dev_clear_o);
endmodule // gbd_checker

bind gbd_decoder gbd_checker chk_u (.clk_sys_i, .rst_i, .ifc_n_i, .dio_n_i, .byte_accepted_i,
   .primary_addr_i, .get_unaddressed_i, .service_need_i, .srq_n_oe_o, .srq_n_o,
   .panel_enable_o, .lockout_o,
   .poll_mode_o, .listen_o, .talk_o, .dev_clear_o, .trigger_o);

// file: verification/gbd_ctl_model.sv
// Behavioural bus controller driving the decoder's bus side.
`timescale 1ns/100ps
module gbd_ctl_model (
   input wire logic clk_sys_i,
   output logic atn_n_o,
   output logic ifc_n_o,
   output logic ren_n_o,
   output logic eoi_n_o,
   output logic acc_o,
   output logic [7:0] dio_n_o
);
   // All lines idle false at start.
   initial begin
      {atn_n_o, ifc_n_o, ren_n_o, eoi_n_o, acc_o, dio_n_o} = 13'h1eff;
   end
   // Lines settle well before the accept pulse so the filtered copy is stable.
   task automatic send(input logic atn, input logic [7:0] b, input logic eoi, input int gap);
      @(posedge clk_sys_i) #2;
      atn_n_o = ~atn;
      dio_n_o = ~b;
      eoi_n_o = ~eoi;
      repeat (5 + gap) @(posedge clk_sys_i);
      #2 acc_o = 1'b1;
      @(posedge clk_sys_i) #2;
      acc_o = 1'b0;
      dio_n_o = b; // Released data shows the inverse, never the old byte.
   endtask
   // Uniline commands are levels held by the controller alone.
   task automatic uni(input logic ifc, input logic ren);
      @(posedge clk_sys_i) #2;
      ifc_n_o = ~ifc;
      ren_n_o = ~ren;
      repeat (6) @(posedge clk_sys_i);
   endtask
endmodule // gbd_ctl_model

// file: verification/tb_top.sv
// Self-checking bench for the bus command decoder.
`timescale 1ns/100ps
module tb_top;
   import gbd_pkg::*;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic atn_n_i, ifc_n_i, ren_n_i, eoi_n_i, byte_accepted_i, srq_n_o, srq_n_oe_o, remote_o;
   logic lockout_o, panel_enable_o, poll_mode_o, listen_o, talk_o, dev_clear_o, trigger_o;
   logic data_valid_o, data_last_o, acc_q, rem, llo, spl, lis, tlk, ren;
   logic get_unaddressed_i = 1'b0;
   logic service_need_i = 1'b0;
   logic [7:0] dio_n_i, data_o, dat;
   logic [4:0] primary_addr_i;
   logic [6:0] seq[];
   logic [16:0] exq[$];
   logic [16:0] got;
   int error_cnt = 0;
   int comparisons = 0;
   always #10 clk_sys_i = ~clk_sys_i;
   gbd_ctl_model ctl_u (.clk_sys_i, .atn_n_o(atn_n_i), .ifc_n_o(ifc_n_i), .ren_n_o(ren_n_i),
      .eoi_n_o(eoi_n_i), .acc_o(byte_accepted_i), .dio_n_o(dio_n_i));
   gbd_decoder dut_u (.clk_sys_i, .rst_i, .atn_n_i, .ifc_n_i, .ren_n_i, .eoi_n_i, .dio_n_i,
      .byte_accepted_i, .primary_addr_i, .get_unaddressed_i, .service_need_i, .srq_n_o,
      .srq_n_oe_o, .remote_o, .lockout_o, .panel_enable_o, .poll_mode_o, .listen_o, .talk_o,
      .dev_clear_o, .trigger_o, .data_valid_o, .data_o, .data_last_o);
   task automatic report_and_stop;
      if (error_cnt == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Predict the flags for one byte, note them, then hand the byte to the controller.
   task automatic xfer(input logic atn, input logic [7:0] b, input logic eoi);
      logic [6:0] c;
      logic l0, clr, trg;
      c = b[6:0];
      l0 = lis;
      {clr, trg} = 2'h0;
      if (atn) begin
         if (ren && (l0 || c == {2'h1, primary_addr_i}) && c != GBD_CMD_GTL) rem = 1'b1;
         if (c == {2'h1, primary_addr_i}) {lis, tlk} = 2'h2;
         else if (c == GBD_CMD_UNL) lis = 1'b0;
         if (c == {2'h2, primary_addr_i}) {lis, tlk} = 2'h1;
         else if (c[6:5] == 2'h2) tlk = 1'b0;
         if (c == GBD_CMD_LLO) llo = 1'b1;
         if (c == GBD_CMD_DCL || (c == GBD_CMD_SDC && l0)) {clr, spl} = 2'h2;
         if (c == GBD_CMD_SPE || c == GBD_CMD_SPD) spl = !c[0];
         if (c == GBD_CMD_GTL && l0) {rem, llo} = 2'h0;
         trg = c == GBD_CMD_GET && (l0 || get_unaddressed_i);
      end else if (l0) dat = b;
      exq.push_back({rem, llo, spl, lis, tlk, clr, trg, !atn && l0, !atn && l0 && eoi, dat});
      ctl_u.send(atn, b, eoi, $urandom % 3);
   endtask
   task automatic lines(input logic ifc, input logic r);
      ren = r;
      if (!r) {rem, llo} = 2'h0;
      if (ifc) {lis, tlk, spl} = 3'h0;
      ctl_u.uni(ifc, r);
   endtask
   always @(posedge clk_sys_i) acc_q <= byte_accepted_i;
   always @(posedge clk_sys_i) service_need_i <= #2 1'($urandom % 2);
   // One result per accepted byte, compared with the oldest note.
   always @(negedge clk_sys_i) if (acc_q) begin
      got = {remote_o, lockout_o, poll_mode_o, listen_o, talk_o, dev_clear_o, trigger_o,
         data_valid_o, data_valid_o & data_last_o, data_o};
      comparisons++;
      if (got !== exq[0]) begin
         error_cnt++;
         $display("[FAIL] outputs expected %h seen %h", exq[0], got);
      end
      void'(exq.pop_front());
   end
   // Addressing, every command code, data with end marker, then clear and local.
   initial begin
      void'($urandom(86));
      {rem, llo, spl, lis, tlk, ren, dat} = 14'h0;
      primary_addr_i = 5'($urandom % 31);
      repeat (3) @(posedge clk_sys_i);
      #2 rst_i = 1'b0;
      xfer(1'b1, {1'b0, GBD_CMD_GET}, 1'b0);
      lines(1'b0, 1'b1);
      seq = '{GBD_CMD_UNL, {2'h1, primary_addr_i}, GBD_CMD_SDC, GBD_CMD_GET, GBD_CMD_LLO,
         GBD_CMD_SPE, {2'h3, primary_addr_i}, GBD_CMD_SPD, GBD_CMD_GTL, {2'h2, primary_addr_i},
         GBD_CMD_DCL, {2'h2, primary_addr_i ^ 5'h01}, GBD_CMD_UNT, {2'h1, primary_addr_i}};
      foreach (seq[i]) xfer(1'b1, {1'($urandom % 2), seq[i]}, 1'b0);
      repeat (3) xfer(1'b0, 8'($urandom), 1'b0);
      xfer(1'b0, 8'($urandom), 1'b1);
      xfer(1'b1, {1'b0, GBD_CMD_UNL}, 1'b0);
      xfer(1'b0, 8'($urandom), 1'b0);
      get_unaddressed_i = 1'b1;
      xfer(1'b1, {1'b0, GBD_CMD_GET}, 1'b0);
      xfer(1'b1, {3'h1, primary_addr_i}, 1'b0);
      lines(1'b1, 1'b1);
      lines(1'b0, 1'b0);
      xfer(1'b1, {3'h1, primary_addr_i}, 1'b0);
      repeat (3) @(posedge clk_sys_i);
      report_and_stop();
   end
   initial begin
      #100us;
      error_cnt++;
      report_and_stop();
   end
endmodule // tb_top
